// >>> hw/rsmc_pkg.sv
package rsmc_pkg;
  // register byte offsets on the bus
  localparam logic [3:0] RSMC_SMC_OFS     = 4'h0;   // supply_monitor_control
  localparam logic [3:0] RSMC_STAT_OFS    = 4'h4;   // status and causes
  localparam logic [3:0] RSMC_CFG_OFS     = 4'h8;   // configuration bytes view
  localparam logic [3:0] RSMC_CORE_OFS    = 4'hC;   // core start vector address
  // supply_monitor_control fields
  localparam int SMC_EN_BIT   = 0;
  localparam int SMC_LVL_LSB  = 1;
  localparam int SMC_ACT_LSB  = 4;
  localparam logic [7:0] SMC_RESET_VAL = 8'h00;
  // supply_monitor_action encodings
  localparam logic [1:0] ACT_RESET  = 2'h0;
  localparam logic [1:0] ACT_FREEZE = 2'h2;
  // configuration byte 20C7 bit positions
  localparam int CFG_POR_BIT   = 0;
  localparam int CFG_REUSE_BIT = 1;
  localparam int CFG_NOISE_BIT = 2;
  localparam int CFG_INOSC_BIT = 3;
  // status bit positions
  localparam int ST_DROP_BIT  = 0;
  localparam int ST_EXT_BIT   = 1;
  localparam int ST_POR_BIT   = 2;
  localparam int ST_WDT_BIT   = 3;
  localparam int ST_RUN_BIT   = 4;
  localparam int ST_FRZ_BIT   = 5;
  // core initial values
  localparam logic [15:0] START_VEC_ADDR  = 16'hFFFE;
  localparam logic [7:0]  RAM_PAGE_INIT   = 8'h00;
  localparam logic [7:0]  ERASED_BYTE     = 8'h00;
  // timing
  localparam int  CLK_HZ          = 100_000_000;
  localparam int  EXT_RST_MIN_CYC = 8;
  localparam int  TAIL_CYC        = 7;
  localparam int  NOISE_NS        = 32_000;
  localparam int  CLK_NS          = 10;
  localparam int  NOISE_CYC       = (NOISE_NS + CLK_NS - 1) / CLK_NS;
  // 65.5 ms at 4 MHz is 262144 oscillator periods
  localparam int  STAB_OSC_PER    = 262_144;
  localparam int  OSC_DIV         = 4;

  typedef enum logic [1:0] {RSMC_ST_RESET, RSMC_ST_STAB, RSMC_ST_TAIL, RSMC_ST_RUN} rsmc_state_t;

  typedef struct packed {
    logic       por_opt;
    logic       reuse_opt;
    logic       noise_opt;
    logic       inosc_opt;
  } rsmc_cfg_t;

  typedef struct packed {
    logic        ram_page_zero;
    logic        direct_page_flag;
    logic        main_clock_sel;
    logic        peri_clock_on;
  } rsmc_core_t;
endpackage : rsmc_pkg

// >>> hw/rsmc_top.sv
`timescale 1ns/1ps
// Function
// - any of pin, power-on, supply monitor or watchdog forces internal reset
// - after release wait stabilisation interval plus seven oscillator periods
// - then load program counter from start vector at top two bytes
// - user RAM contents are never cleared by any reset
// - reset clears ram page index, direct-page flag; main clock, peripheral clock on
// - power-on detector holds reset until supply is adequate
// - power-on and reuse options set: reset pin becomes port input bit
// - power-on set, reuse clear: reset pin stays external reset
// - control register enables or disables supply-level reset circuitry
// - two-bit level select picks one of four detection thresholds
// - low-supply pulses shorter than 32 us are ignored
// - action 00 turns filtered detection into internal reset
// - action 10 freezes CPU until supply returns to normal
// - supply-drop flag set on every supply-level detection
// - noise guard enabled by a configuration byte bit
// - enabled guard restores corrupted or missing clock pulses
// - internal oscillator option: run from guard osc, drive pin at divide four
// - options come from two non-volatile configuration bytes
// - erased program memory reads as all zeros
module rsmc_top
  import rsmc_pkg::*;
#(
  parameter int STAB_CYC = STAB_OSC_PER,
  parameter int NOISE_FILT_CYC = NOISE_CYC
) (
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_reset_pin_n,
  input  wire logic        i_supply_ok,
  input  wire logic        i_watchdog_rst,
  input  wire logic [3:0]  i_supply_low_lvl,
  input  wire logic [7:0]  i_cfg_byte_lock,
  input  wire logic [7:0]  i_cfg_byte_opt,
  input  wire logic        i_main_osc_pulse,
  input  wire logic        i_guard_osc_pulse,
  input  wire logic [31:0] i_wb_adr,
  input  wire logic [31:0] i_wb_dat,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic        i_wb_we,
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  output logic [31:0]      o_wb_dat,
  output logic             o_wb_ack,
  output logic             o_core_rst,
  output logic             o_cpu_freeze,
  output logic             o_fetch_start,
  output logic [15:0]      o_vector_addr,
  output logic [7:0]       o_ram_page_index,
  output logic             o_direct_page_flag,
  output logic             o_main_clock_sel,
  output logic             o_peri_clock_on,
  output logic             o_sys_clk_en,
  output logic             o_osc_out,
  output logic             o_reset_pin_as_port_input,
  output logic [7:0]       o_erased_byte,
  output logic             o_ram_clear
);

  localparam int SCW = $clog2(STAB_CYC + TAIL_CYC + 1);
  localparam int NCW = $clog2(NOISE_FILT_CYC + 1);

  // 2-bit wrap counter used for the oscillator divider
  function automatic logic [1:0] inc2(input logic [1:0] v);
    inc2 = v + 2'h1;
  endfunction : inc2

  // register offset decode; upper address bits must be clear so nothing aliases
  function automatic logic reg_hit(input logic [31:0] adr, input logic [3:0] ofs);
    reg_hit = (adr[31:4] == 28'h0000000) && (adr[3:0] == ofs);
  endfunction : reg_hit

  // state registers
  rsmc_state_t     state_r, state_nxt;
  logic [SCW-1:0]  cnt_r, cnt_nxt;
  logic [NCW-1:0]  pin_cnt_r, pin_cnt_nxt;
  logic [NCW-1:0]  low_cnt_r, low_cnt_nxt;
  logic            pin_valid_r, pin_valid_nxt;
  logic            low_filt_r, low_filt_nxt;
  logic [7:0]      smc_r, smc_nxt;
  logic [5:0]      stat_r, stat_nxt;
  rsmc_cfg_t       cfg_r, cfg_nxt;
  logic [7:0]      lock_r, lock_nxt;
  logic [1:0]      div_r, div_nxt;
  logic            osc_out_nxt;
  logic            ack_nxt;
  logic [31:0]     rdat_nxt;
  logic            sysclk_nxt;
  // core-facing next values
  logic            core_rst_nxt;
  logic            freeze_nxt;
  logic            fetch_nxt;
  logic [15:0]     vec_nxt;
  logic [7:0]      page_nxt;
  logic            dpf_nxt;
  logic            mcs_nxt;
  logic            pco_nxt;
  logic            pin_port_nxt;
  logic [7:0]      erased_nxt;
  logic            ram_clear_nxt;

  logic            pin_is_reset;
  logic            low_raw;
  logic            brownout_reset_path;
  logic            any_reset;
  logic            wr_stb;
  logic            rd_stb;
  logic            osc_pulse;

  // reset pin role from options
  assign pin_is_reset = !(cfg_r.por_opt && cfg_r.reuse_opt);
  // level compare: detector reports low per threshold index
  assign low_raw = smc_r[SMC_EN_BIT]
                   && i_supply_low_lvl[smc_r[SMC_LVL_LSB +: 2]];
  assign brownout_reset_path = low_filt_r && (smc_r[SMC_ACT_LSB +: 2] == ACT_RESET);
  assign any_reset = (pin_is_reset && pin_valid_r) || !i_supply_ok
                     || brownout_reset_path || i_watchdog_rst;
  assign wr_stb = i_wb_cyc && i_wb_stb && i_wb_we && !o_wb_ack;
  // read request, data is registered with the ack
  assign rd_stb = i_wb_cyc && i_wb_stb && !i_wb_we;
  // guard fills in a missing main pulse with its own oscillator
  assign osc_pulse = cfg_r.inosc_opt ? i_guard_osc_pulse
                     : (i_main_osc_pulse || (cfg_r.noise_opt && i_guard_osc_pulse));

  // reset filters and sequencer next state
  always_comb begin
    state_nxt     = state_r;
    cnt_nxt       = cnt_r;
    pin_cnt_nxt   = pin_cnt_r;
    pin_valid_nxt = pin_valid_r;
    low_cnt_nxt   = low_cnt_r;
    low_filt_nxt  = low_filt_r;
    // pin qualification, at least eight periods low
    if (i_reset_pin_n) begin
      pin_cnt_nxt   = '0;
      pin_valid_nxt = 1'b0;
    end else if (pin_cnt_r < NCW'(EXT_RST_MIN_CYC - 1)) begin
      pin_cnt_nxt = pin_cnt_r + NCW'(1);
    end else begin
      pin_valid_nxt = 1'b1;
    end
    // noise canceller on low-supply detection
    if (!low_raw) begin
      low_cnt_nxt  = '0;
      low_filt_nxt = 1'b0;
    end else if (low_cnt_r < NCW'(NOISE_FILT_CYC - 1)) begin
      low_cnt_nxt = low_cnt_r + NCW'(1);
    end else begin
      low_filt_nxt = 1'b1;
    end
    unique case (state_r)
      RSMC_ST_RESET: begin
        cnt_nxt = '0;
        if (!any_reset) begin
          state_nxt = RSMC_ST_STAB;
        end
      end
      RSMC_ST_STAB: begin
        if (cnt_r == SCW'(STAB_CYC - 1)) begin
          state_nxt = RSMC_ST_TAIL;
          cnt_nxt   = '0;
        end else begin
          cnt_nxt = cnt_r + SCW'(1);
        end
      end
      RSMC_ST_TAIL: begin
        if (cnt_r == SCW'(TAIL_CYC - 1)) begin
          state_nxt = RSMC_ST_RUN;
        end else begin
          cnt_nxt = cnt_r + SCW'(1);
        end
      end
      RSMC_ST_RUN: begin
        cnt_nxt = '0;
      end
    endcase
    if (any_reset) begin
      state_nxt = RSMC_ST_RESET;
    end
  end

  // register file, bus answer and clock outputs
  always_comb begin
    smc_nxt     = smc_r;
    stat_nxt    = stat_r;
    cfg_nxt     = cfg_r;
    lock_nxt    = lock_r;
    div_nxt     = div_r;
    osc_out_nxt = o_osc_out;
    ack_nxt     = i_wb_cyc && i_wb_stb && !o_wb_ack;
    rdat_nxt    = '0;
    sysclk_nxt  = osc_pulse;
    // option bytes latched while held in reset
    if (state_r == RSMC_ST_RESET) begin
      cfg_nxt.por_opt   = i_cfg_byte_opt[CFG_POR_BIT];
      cfg_nxt.reuse_opt = i_cfg_byte_opt[CFG_REUSE_BIT];
      cfg_nxt.noise_opt = i_cfg_byte_opt[CFG_NOISE_BIT];
      cfg_nxt.inosc_opt = i_cfg_byte_opt[CFG_INOSC_BIT];
      lock_nxt          = i_cfg_byte_lock;
      smc_nxt           = SMC_RESET_VAL;
    end
    // software writes, clear-by-one on the status drop flag only
    if (wr_stb && i_wb_sel[0]) begin
      if (reg_hit(i_wb_adr, RSMC_SMC_OFS)) begin
        smc_nxt = i_wb_dat[7:0];
      end
      if (reg_hit(i_wb_adr, RSMC_STAT_OFS) && i_wb_dat[ST_DROP_BIT]) begin
        stat_nxt[ST_DROP_BIT] = 1'b0;
      end
    end
    // hardware set wins over software clear
    if (low_filt_r) begin
      stat_nxt[ST_DROP_BIT] = 1'b1;
    end
    if (pin_is_reset && pin_valid_r) begin
      stat_nxt[ST_EXT_BIT] = 1'b1;
    end
    if (!i_supply_ok) begin
      stat_nxt[ST_POR_BIT] = 1'b1;
    end
    if (i_watchdog_rst) begin
      stat_nxt[ST_WDT_BIT] = 1'b1;
    end
    stat_nxt[ST_RUN_BIT] = (state_r == RSMC_ST_RUN);
    stat_nxt[ST_FRZ_BIT] = o_cpu_freeze;
    // read mux, offsets outside the map read as zero
    if (rd_stb) begin
      if (reg_hit(i_wb_adr, RSMC_SMC_OFS)) begin
        rdat_nxt = {24'h000000, smc_r};
      end else if (reg_hit(i_wb_adr, RSMC_STAT_OFS)) begin
        rdat_nxt = {26'h0000000, stat_r};
      end else if (reg_hit(i_wb_adr, RSMC_CFG_OFS)) begin
        // options in configuration byte order, power-on option at bit 0
        rdat_nxt = {20'h00000, lock_r, cfg_r.inosc_opt, cfg_r.noise_opt, cfg_r.reuse_opt, cfg_r.por_opt};
      end else if (reg_hit(i_wb_adr, RSMC_CORE_OFS)) begin
        rdat_nxt = {16'h0000, START_VEC_ADDR};
      end
    end
    // divide-by-four on the oscillator output pin
    if (osc_pulse) begin
      div_nxt = inc2(div_r);
      if (div_r == 2'h1 || div_r == 2'h3) begin
        osc_out_nxt = !o_osc_out;
      end
    end
  end

  // register the reset filters
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      pin_cnt_r   <= '0;
      pin_valid_r <= 1'b0;
      low_cnt_r   <= '0;
      low_filt_r  <= 1'b0;
    end else begin
      pin_cnt_r   <= pin_cnt_nxt;
      pin_valid_r <= pin_valid_nxt;
      low_cnt_r   <= low_cnt_nxt;
      low_filt_r  <= low_filt_nxt;
    end
  end

  // register the sequencer
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state_r <= RSMC_ST_RESET;
      cnt_r   <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  // register the software visible state
  // only the system reset clears the other status causes; the drop flag is also cleared by writing one, and it outlives its own reset
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      smc_r  <= SMC_RESET_VAL;
      stat_r <= '0;
      cfg_r  <= '0;
      lock_r <= '0;
    end else begin
      smc_r  <= smc_nxt;
      stat_r <= stat_nxt;
      cfg_r  <= cfg_nxt;
      lock_r <= lock_nxt;
    end
  end

  // register the bus answer
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= '0;
    end else begin
      o_wb_ack <= ack_nxt;
      o_wb_dat <= rdat_nxt;
    end
  end

  // register the clock outputs
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      div_r        <= '0;
      o_osc_out    <= 1'b0;
      o_sys_clk_en <= 1'b0;
    end else begin
      div_r        <= div_nxt;
      o_osc_out    <= osc_out_nxt;
      o_sys_clk_en <= sysclk_nxt;
    end
  end

  // core-facing next values; power-up state is forced while not running
  always_comb begin
    core_rst_nxt  = (state_nxt != RSMC_ST_RUN);
    freeze_nxt    = low_filt_nxt && (smc_r[SMC_ACT_LSB +: 2] == ACT_FREEZE);
    fetch_nxt     = (state_r == RSMC_ST_TAIL) && (state_nxt == RSMC_ST_RUN);
    vec_nxt       = START_VEC_ADDR;
    page_nxt      = o_ram_page_index;
    dpf_nxt       = o_direct_page_flag;
    mcs_nxt       = o_main_clock_sel;
    pco_nxt       = o_peri_clock_on;
    if (state_nxt != RSMC_ST_RUN) begin
      page_nxt = RAM_PAGE_INIT;
      dpf_nxt  = 1'b0;
      mcs_nxt  = 1'b1;
      pco_nxt  = 1'b1;
    end
    pin_port_nxt  = !pin_is_reset && !i_reset_pin_n;
    erased_nxt    = ERASED_BYTE;
    ram_clear_nxt = 1'b0;
  end

  // core-facing outputs, all registered
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_core_rst          <= 1'b1;
      o_cpu_freeze        <= 1'b0;
      o_fetch_start       <= 1'b0;
      o_vector_addr       <= START_VEC_ADDR;
      o_ram_page_index    <= RAM_PAGE_INIT;
      o_direct_page_flag  <= 1'b0;
      o_main_clock_sel    <= 1'b1;
      o_peri_clock_on     <= 1'b1;
      o_reset_pin_as_port_input <= 1'b0;
      o_erased_byte       <= ERASED_BYTE;
      o_ram_clear         <= 1'b0;
    end else begin
      o_core_rst                <= core_rst_nxt;
      o_cpu_freeze              <= freeze_nxt;
      o_fetch_start             <= fetch_nxt;
      o_vector_addr             <= vec_nxt;
      o_ram_page_index          <= page_nxt;
      o_direct_page_flag        <= dpf_nxt;
      o_main_clock_sel          <= mcs_nxt;
      o_peri_clock_on           <= pco_nxt;
      o_reset_pin_as_port_input <= pin_port_nxt;
      o_erased_byte             <= erased_nxt;
      o_ram_clear               <= ram_clear_nxt;
    end
  end

endmodule : rsmc_top

// >>> test/rsmc_chk_sva.sv
`timescale 1ns/1ps
module rsmc_chk
  import rsmc_pkg::*;
#(
  parameter int STAB_CYC       = 20,
  parameter int NOISE_FILT_CYC = 10
) (
  input wire logic        i_clk,
  input wire logic        i_sys_rst,
  input wire logic        i_watchdog_rst,
  input wire logic [3:0]  i_supply_low_lvl,
  input wire logic        o_core_rst,
  input wire logic        o_cpu_freeze,
  input wire logic        o_fetch_start,
  input wire logic [15:0] o_vector_addr,
  input wire logic [7:0]  o_ram_page_index,
  input wire logic        o_direct_page_flag,
  input wire logic        o_main_clock_sel,
  input wire logic        o_peri_clock_on,
  input wire logic [7:0]  o_erased_byte,
  input wire logic        o_ram_clear
);
  logic [19:0] rst_cnt_r, rst_cnt_nxt, low_cnt_r, low_cnt_nxt;
  // length of core reset and of low supply
  always_comb begin
    rst_cnt_nxt = o_core_rst ? rst_cnt_r + 20'h1 : 20'h0;
    low_cnt_nxt = (|i_supply_low_lvl) ? low_cnt_r + 20'h1 : 20'h0;
  end
  always_ff @(posedge i_clk) begin
    rst_cnt_r <= i_sys_rst ? 20'h0 : rst_cnt_nxt;
    low_cnt_r <= low_cnt_nxt;
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  a_wdt_forces_reset: assert property (
    i_watchdog_rst |-> ##[1:3] o_core_rst) else $error("watchdog left core running");
  a_release_wait: assert property (
    $fell(o_core_rst) |-> rst_cnt_r >= 20'(STAB_CYC + TAIL_CYC)) else $error("reset released early");
  a_fetch_once: assert property (
    o_fetch_start |-> !o_core_rst && $past(o_core_rst) ##1 !o_fetch_start) else $error("bad fetch pulse");
  a_vector_fixed: assert property (
    o_vector_addr == START_VEC_ADDR) else $error("start vector wrong");
  a_reset_state: assert property (
    o_core_rst && $past(o_core_rst) |-> o_ram_page_index == RAM_PAGE_INIT && !o_direct_page_flag
      && o_main_clock_sel && o_peri_clock_on) else $error("core state wrong in reset");
  a_ram_kept: assert property (
    !o_ram_clear) else $error("ram cleared");
  a_noise_filter: assert property (
    $rose(o_cpu_freeze) |-> low_cnt_r >= 20'(NOISE_FILT_CYC - 1)) else $error("short dip froze cpu");
  a_freeze_ends: assert property (
    !(|i_supply_low_lvl) [*4] |-> !o_cpu_freeze) else $error("freeze outlived low supply");
  a_erased_zero: assert property (
    o_erased_byte == ERASED_BYTE) else $error("erased byte not zero");
endmodule : rsmc_chk

bind rsmc_top rsmc_chk #(.STAB_CYC(STAB_CYC), .NOISE_FILT_CYC(NOISE_FILT_CYC)) u_chk (
  .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_watchdog_rst(i_watchdog_rst), .i_supply_low_lvl(i_supply_low_lvl),
  .o_core_rst(o_core_rst), .o_cpu_freeze(o_cpu_freeze), .o_fetch_start(o_fetch_start),
  .o_vector_addr(o_vector_addr), .o_ram_page_index(o_ram_page_index), .o_direct_page_flag(o_direct_page_flag),
  .o_main_clock_sel(o_main_clock_sel), .o_peri_clock_on(o_peri_clock_on), .o_erased_byte(o_erased_byte),
  .o_ram_clear(o_ram_clear));

// >>> test/rsmc_far_model.sv
`timescale 1ns/1ps
module rsmc_far_model (
  input  wire logic  i_clk,
  output logic       o_reset_pin_n,
  output logic       o_supply_ok,
  output logic [3:0] o_supply_low_lvl,
  output logic       o_main_osc_pulse,
  output logic       o_guard_osc_pulse
);
  logic [1:0] div_r;
  // idle: pin high, supply good
  initial begin
    div_r = 2'h0;
    o_reset_pin_n = 1'b1;
    o_supply_ok = 1'b1;
    o_supply_low_lvl = 4'h0;
  end
  // main tick every 4 cycles, guard every 2
  always @(posedge i_clk) begin
    div_r <= div_r + 2'h1;
  end
  assign o_main_osc_pulse  = (div_r == 2'h3);
  assign o_guard_osc_pulse = div_r[0];
  // pin and rail levels, set just after an edge
  task automatic drive(input logic pin_n, input logic ok, input logic [3:0] low);
    o_reset_pin_n <= pin_n;
    o_supply_ok <= ok;
    o_supply_low_lvl <= low;
  endtask : drive
endmodule : rsmc_far_model

// >>> test/test_reset_supply_monitor_ctrl.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin miscompares++; $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module test_reset_supply_monitor_ctrl;
  import rsmc_pkg::*;
  localparam int STAB = 20;
  localparam int FILT = 10;
  logic        clk, sys_rst, pin_n, ok, wdt, mtick, gtick, we, cyc, stb, ack, core_rst, freeze, fetch;
  logic        dpf, mcs, pco, sclk, osc, pin_port, ram_clr, po;
  logic [3:0]  low, sel;
  logic [7:0]  lock, opt, page, erased;
  logic [15:0] vec;
  logic [31:0] adr, wdat, rdat, q;
  int          miscompares, n_tests, t, k, chg, ns;
  rsmc_far_model u_far (.i_clk(clk), .o_reset_pin_n(pin_n), .o_supply_ok(ok), .o_supply_low_lvl(low),
    .o_main_osc_pulse(mtick), .o_guard_osc_pulse(gtick));
  rsmc_top #(.STAB_CYC(STAB), .NOISE_FILT_CYC(FILT)) i_dut (.i_clk(clk), .i_sys_rst(sys_rst),
    .i_reset_pin_n(pin_n), .i_supply_ok(ok), .i_watchdog_rst(wdt), .i_supply_low_lvl(low),
    .i_cfg_byte_lock(lock), .i_cfg_byte_opt(opt), .i_main_osc_pulse(mtick), .i_guard_osc_pulse(gtick),
    .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel), .i_wb_we(we), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .o_wb_dat(rdat), .o_wb_ack(ack), .o_core_rst(core_rst), .o_cpu_freeze(freeze), .o_fetch_start(fetch),
    .o_vector_addr(vec), .o_ram_page_index(page), .o_direct_page_flag(dpf), .o_main_clock_sel(mcs),
    .o_peri_clock_on(pco), .o_sys_clk_en(sclk), .o_osc_out(osc), .o_reset_pin_as_port_input(pin_port),
    .o_erased_byte(erased), .o_ram_clear(ram_clr));
  // clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic stop_test();
    $display("comparisons %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test
  // one classic bus cycle, held until ack
  task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d);
    int n;
    n = 0;
    adr <= {24'h0, a};
    wdat <= {24'h0, d};
    we <= w;
    cyc <= 1'b1;
    stb <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) miscompares++;
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : wb
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    wb(a, 1'b0, 8'h00);
    `CHK(nm, e, q & m)
  endtask : rd
  task automatic boot();
    t = 0;
    do begin
      @(posedge clk);
      t++;
    end while (fetch !== 1'b1 && t < 500);
    if (t >= 500) miscompares++;
  endtask : boot
  task automatic pulse(input logic p, input logic s, input logic [3:0] l, input int n);
    u_far.drive(p, s, l);
    repeat (n) @(posedge clk);
    u_far.drive(1'b1, 1'b1, 4'h0);
  endtask : pulse
  // hang guard
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    stop_test();
  end
  // main sequence
  initial begin
    miscompares = 0;
    n_tests = 0;
    sys_rst = 1'b1;
    wdt = 1'b0;
    lock = 8'h5A;
    opt = 8'h01;
    adr = 32'h0;
    wdat = 32'h0;
    sel = 4'hF;
    we = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    repeat (12) @(posedge clk);
    `CHK("rst_page", RAM_PAGE_INIT, page)
    `CHK("rst_clocks", 3'b011, {dpf, mcs, pco})
    `CHK("vector", START_VEC_ADDR, vec)
    sys_rst <= 1'b0;
    boot();
    `CHK("boot_wait", 1'b1, t >= STAB + TAIL_CYC && t <= STAB + TAIL_CYC + 5)
    rd("core_vec", 8'h0C, 32'hFFFF, 32'hFFFE);
    rd("cfg_view", 8'h08, 32'hFFF, 32'h5A1);
    rd("unmapped", 8'h10, 32'hFFFFFFFF, 32'h0);
    wdt <= 1'b1;
    @(posedge clk);
    wdt <= 1'b0;
    repeat (4) @(posedge clk);
    `CHK("wdt_rst", 1'b1, core_rst)
    boot();
    rd("wdt_seen", 8'h04, 32'h8, 32'h8);
    pulse(1'b0, 1'b1, 4'h0, 5);
    `CHK("pin_short", 1'b0, core_rst)
    pulse(1'b0, 1'b1, 4'h0, 10);
    `CHK("pin_rst", 1'b1, core_rst)
    boot();
    rd("pin_seen", 8'h04, 32'h2, 32'h2);
    pulse(1'b1, 1'b0, 4'h0, 30);
    `CHK("por_rst", 1'b1, core_rst)
    boot();
    rd("por_seen", 8'h04, 32'h4, 32'h4);
    for (k = 0; k < 4; k++) begin
      wb(8'h00, 1'b1, 8'(k * 2 + 1));
      rd("smc", 8'h00, 32'hFF, 32'(k * 2 + 1));
      pulse(1'b1, 1'b1, 4'(1 << k), FILT - 4);
      rd("drop_short", 8'h04, 32'h1, 32'h0);
      pulse(1'b1, 1'b1, 4'(1 << k), FILT * 2);
      `CHK("drop_rst", 1'b1, core_rst)
      boot();
      rd("drop_flag", 8'h04, 32'h1, 32'h1);
      rd("smc_after", 8'h00, 32'hFF, 32'h0);
      wb(8'h04, 1'b1, 8'h01);
      rd("flag_clr", 8'h04, 32'h1, 32'h0);
    end
    wb(8'h00, 1'b1, 8'h21);
    u_far.drive(1'b1, 1'b1, 4'h1);
    repeat (FILT * 2) @(posedge clk);
    `CHK("frz_on", 2'b10, {freeze, core_rst})
    u_far.drive(1'b1, 1'b1, 4'h0);
    repeat (6) @(posedge clk);
    `CHK("frz_off", 1'b0, freeze)
    wb(8'h04, 1'b1, 8'h01);
    wb(8'h00, 1'b1, 8'h00);
    pulse(1'b1, 1'b1, 4'hF, FILT * 2);
    `CHK("off_norst", 1'b0, core_rst)
    rd("off_noflag", 8'h04, 32'h1, 32'h0);
    sys_rst <= 1'b1;
    opt <= 8'h0B;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    boot();
    u_far.drive(1'b0, 1'b1, 4'h0);
    repeat (12) @(posedge clk);
    `CHK("pin_port", 2'b10, {pin_port, core_rst})
    u_far.drive(1'b1, 1'b1, 4'h0);
    chg = 0;
    ns = 0;
    po = osc;
    repeat (64) begin
      @(posedge clk);
      chg += (osc !== po);
      ns += int'(sclk === 1'b1);
      po = osc;
    end
    `CHK("osc_div", 1'b1, chg >= 15 && chg <= 17)
    `CHK("sys_clk", 32, ns)
    `CHK("erased", ERASED_BYTE, erased)
    `CHK("ram_kept", 1'b0, ram_clr)
    stop_test();
  end
endmodule : test_reset_supply_monitor_ctrl
